// file: pkg/ccr_pkg.sv
// package: register map, field layout, timing and types of the charger config registers
`default_nettype none
package ccr_pkg;
	// ****************************************
	// register map and reset values
	// ****************************************
	localparam logic [7:0] CHARGE_TIMING_OFS    = 8'h05;
	localparam logic [7:0] INPUT_THRESHOLD_OFS  = 8'h06;
	localparam logic [7:0] POWER_PATH_OFS       = 8'h07;
	localparam logic [7:0] CHARGE_TIMING_RST    = 8'h9f;
	localparam logic [7:0] INPUT_THRESHOLD_RST  = 8'h66;
	localparam logic [7:0] POWER_PATH_RST       = 8'h4c;
	// power-path bits that survive supervision expiry
	localparam logic [7:0] POWER_PATH_KEEP_MASK = 8'h2b;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TERM_EN_BIT   = 7;
	localparam int WDOG_LSB      = 4;
	localparam int SAFETY_EN_BIT = 3;
	localparam int FAST_DUR_BIT  = 2;
	localparam int THERM_BIT     = 1;
	localparam int COLD_BIT      = 0;
	localparam int OVP_LSB       = 6;
	localparam int BOOST_LSB     = 4;
	localparam int INPUT_VOLTAGE_REG_THRESHOLD_LSB    = 0;
	localparam int DETECT_BIT    = 7;
	localparam int SLOW_BIT      = 6;
	localparam int SW_OFF_BIT    = 5;
	localparam int WARM_BIT      = 4;
	localparam int SW_DLY_BIT    = 3;
	localparam int SW_RST_BIT    = 2;
	localparam int TRACK_LSB     = 0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ           = 10_000_000;
	localparam int WDOG_BASE_S      = 40;
	localparam int SAFETY_SHORT_H   = 5;
	localparam int SECONDS_PER_HOUR = 3600;
	localparam int SWITCH_OFF_DLY_S = 10;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       vbus_present;
		logic       charging;
		logic       slow_condition;
		logic       detection_done;
	} ccr_ext_s;

	typedef struct packed {
		logic       term_enable;
		logic [1:0] watchdog_sel;
		logic       safety_enable;
		logic       fast_charge_duration;
		logic       thermal_reg_threshold;
		logic       cold_zone_current_sel;
		logic [1:0] input_overvoltage_sel;
		logic [1:0] boost_voltage_sel;
		logic [3:0] input_voltage_reg_threshold;
		logic       timer_slowdown_enable;
		logic       warm_zone_voltage_sel;
		logic       switch_off_delay_sel;
		logic       switch_system_reset_enable;
		logic [1:0] input_threshold_tracking;
	} ccr_cfg_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_PTR   = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK  = 3'b110
	} ccr_state_e;
endpackage
`default_nettype wire

// file: rtl/ccr_top.sv
// charger configuration registers 0x05..0x07 behind a serial control slave
// Contract
// - charge-timing register resets to 0x9f.
// - supervision field: 00 off, 01 40 s, 10 80 s, 11 160 s.
// - safety enable bit gates both precharge and fast charge timers; the code has one safety timer, run while charging_i is high.
// - fast charge duration bit: 0 gives 5 hours, 1 gives 10 hours.
// - input-threshold register resets to 0x66.
// - input regulation threshold is 3.9 V plus 100 mV per code step.
// - force-detection bit starts detection with input present, self-clears when done.
// - slow-down bit halves safety timer rate during regulation or cool zone.
// - switch-off bit 0 lets switch conduct, 1 turns it off.
// - warm-zone voltage bit selects 4.1 V cap or programmed voltage.
// - delay bit 0 switches off at once, 1 after 10 s.
// - switch system reset enable bit defaults set, exported as stored.
// - tracking field 00 keeps threshold, 01 tracks battery plus 200 mV.
// - power-path register resets to 0x4c.
// - supervision expiry raises a read-only fault flag.
`timescale 1ns/1ns
`default_nettype none
module ccr_top #(
	parameter logic [6:0]      DEV_ADDR          = 7'h2a, // arbitrary value
	parameter int unsigned     WDOG_BASE_CYC     = ccr_pkg::WDOG_BASE_S * ccr_pkg::CLK_HZ,
	parameter longint unsigned SAFETY_SHORT_CYC  = 64'(ccr_pkg::SAFETY_SHORT_H)
		* 64'(ccr_pkg::SECONDS_PER_HOUR) * 64'(ccr_pkg::CLK_HZ),
	parameter int unsigned     SWITCH_DLY_CYC    = ccr_pkg::SWITCH_OFF_DLY_S * ccr_pkg::CLK_HZ
) (
	// clock and reset
	input  wire logic              mclk_i,
	input  wire logic              resetn_i,
	// serial control pins
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oen_o,
	// charger status from analog side
	input  wire logic              vbus_present_i,
	input  wire logic              charging_i,
	input  wire logic              slow_condition_i,
	input  wire logic              detection_done_i,
	input  wire logic              reg_reset_i,
	// configuration and control outputs
	output ccr_pkg::ccr_cfg_s      cfg_o,
	output logic                   detection_start_o,
	output logic                   detection_active_o,
	output logic                   watchdog_fault_o,
	output logic                   safety_expired_o,
	output logic                   battery_switch_on_o
);
	// ****************************************
	// input synchronisers
	// ****************************************
	ccr_pkg::ccr_ext_s ext_meta_q;
	ccr_pkg::ccr_ext_s ext_q;
	logic              scl_prev_q;
	logic              sda_prev_q;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ext_meta_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			ext_q      <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			ext_meta_q <= '{scl: scl_i, sda: sda_i, vbus_present: vbus_present_i,
				charging: charging_i, slow_condition: slow_condition_i,
				detection_done: detection_done_i};
			ext_q      <= ext_meta_q;
			scl_prev_q <= ext_q.scl;
			sda_prev_q <= ext_q.sda;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = ext_q.scl & ~scl_prev_q;
	assign scl_fall  = ~ext_q.scl & scl_prev_q;
	assign bus_start = ext_q.scl & scl_prev_q & sda_prev_q & ~ext_q.sda;
	assign bus_stop  = ext_q.scl & scl_prev_q & ~sda_prev_q & ext_q.sda;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] chg_q;
	logic [7:0] thr_q;
	logic [7:0] pwr_q;

	function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input logic [7:0] c,
		input logic [7:0] t, input logic [7:0] p);
		if (ofs == ccr_pkg::CHARGE_TIMING_OFS)
			rd_byte = c;
		else if (ofs == ccr_pkg::INPUT_THRESHOLD_OFS)
			rd_byte = t;
		else if (ofs == ccr_pkg::POWER_PATH_OFS)
			rd_byte = p;
		else
			rd_byte = 8'h00;
	endfunction

	// ****************************************
	// serial control slave
	// ****************************************
	ccr_pkg::ccr_state_e state_q;
	logic [3:0]          bitcnt_q;
	logic [7:0]          shreg_q;
	logic [7:0]          ptr_q;
	logic                rw_q;
	logic                first_q;
	logic                wr_stb;
	logic                addr_hit;
	logic [7:0]          rd_now;

	assign wr_stb   = scl_fall && state_q == ccr_pkg::ST_WDATA && bitcnt_q == 4'h8;
	assign addr_hit = scl_fall && state_q == ccr_pkg::ST_ADDR && bitcnt_q == 4'h8
		&& shreg_q[7:1] == DEV_ADDR;
	assign rd_now   = rd_byte(ptr_q, chg_q, thr_q, pwr_q);

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q   <= ccr_pkg::ST_IDLE;
			bitcnt_q  <= 4'h0;
			shreg_q   <= 8'h00;
			ptr_q     <= 8'h00;
			rw_q      <= 1'b0;
			first_q   <= 1'b0;
			sda_oen_o <= 1'b1;
		end
		else if (bus_start)
		begin
			state_q   <= ccr_pkg::ST_ADDR;
			bitcnt_q  <= 4'h0;
			sda_oen_o <= 1'b1;
		end
		else if (bus_stop)
		begin
			state_q   <= ccr_pkg::ST_IDLE;
			sda_oen_o <= 1'b1;
		end
		else
		begin
			case (state_q)
				ccr_pkg::ST_ADDR, ccr_pkg::ST_PTR, ccr_pkg::ST_WDATA:
				begin
					if (scl_rise && bitcnt_q != 4'h8)
					begin
						shreg_q  <= {shreg_q[6:0], ext_q.sda};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					else if (scl_fall && bitcnt_q == 4'h8)
					begin
						sda_oen_o <= 1'b0;
						state_q   <= ccr_pkg::ST_ACK;
						if (state_q == ccr_pkg::ST_ADDR)
						begin
							rw_q    <= shreg_q[0];
							first_q <= 1'b1;
							if (!addr_hit)
							begin
								sda_oen_o <= 1'b1;
								state_q   <= ccr_pkg::ST_IDLE;
							end
						end
						else if (state_q == ccr_pkg::ST_PTR)
						begin
							ptr_q   <= shreg_q;
							first_q <= 1'b0;
						end
						else
							ptr_q <= ptr_q + 8'h01;
					end
				end
				ccr_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						bitcnt_q <= 4'h0;
						if (rw_q)
						begin
							shreg_q   <= rd_now;
							ptr_q     <= ptr_q + 8'h01;
							sda_oen_o <= rd_now[7];
							state_q   <= ccr_pkg::ST_RDATA;
						end
						else
						begin
							sda_oen_o <= 1'b1;
							state_q   <= first_q ? ccr_pkg::ST_PTR : ccr_pkg::ST_WDATA;
						end
					end
				end
				ccr_pkg::ST_RDATA:
				begin
					if (scl_rise)
					begin
						shreg_q  <= {shreg_q[6:0], 1'b0};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					else if (scl_fall)
					begin
						sda_oen_o <= (bitcnt_q == 4'h8) ? 1'b1 : shreg_q[7];
						if (bitcnt_q == 4'h8)
							state_q <= ccr_pkg::ST_RACK;
					end
				end
				ccr_pkg::ST_RACK:
				begin
					if (scl_rise)
						state_q <= ext_q.sda ? ccr_pkg::ST_IDLE : ccr_pkg::ST_ACK;
				end
				default:
				begin
					state_q <= ccr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// open-drain: only ever pulls low
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// ****************************************
	// supervision timer
	// ****************************************
	logic [31:0] wdog_cnt_q;
	logic [31:0] wdog_limit;
	logic        wdog_expire;

	always_comb
	begin
		case (chg_q[ccr_pkg::WDOG_LSB +: 2])
			2'b01:   wdog_limit = 32'(WDOG_BASE_CYC);
			2'b10:   wdog_limit = 32'(WDOG_BASE_CYC) << 1;
			2'b11:   wdog_limit = 32'(WDOG_BASE_CYC) << 2;
			default: wdog_limit = 32'h0000_0000;
		endcase
	end
	assign wdog_expire = wdog_limit != 32'h0 && wdog_cnt_q == wdog_limit - 32'h1;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wdog_cnt_q <= 32'h0;
		else if (addr_hit || wdog_expire || wdog_limit == 32'h0 || reg_reset_i)
			wdog_cnt_q <= 32'h0;
		else
			wdog_cnt_q <= wdog_cnt_q + 32'h1;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			watchdog_fault_o <= 1'b0;
		else if (wdog_expire)
			watchdog_fault_o <= 1'b1;
		else if (addr_hit || reg_reset_i)
			watchdog_fault_o <= 1'b0;
	end

	// ****************************************
	// register writes and defaults
	// ****************************************
	logic det_set;
	assign det_set = wr_stb && ptr_q == ccr_pkg::POWER_PATH_OFS
		&& shreg_q[ccr_pkg::DETECT_BIT] && ext_q.vbus_present;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			chg_q <= ccr_pkg::CHARGE_TIMING_RST;
			thr_q <= ccr_pkg::INPUT_THRESHOLD_RST;
			pwr_q <= ccr_pkg::POWER_PATH_RST;
		end
		else if (reg_reset_i)
		begin
			chg_q <= ccr_pkg::CHARGE_TIMING_RST;
			thr_q <= ccr_pkg::INPUT_THRESHOLD_RST;
			pwr_q <= ccr_pkg::POWER_PATH_RST;
		end
		else if (wdog_expire)
		begin
			chg_q <= ccr_pkg::CHARGE_TIMING_RST;
			pwr_q <= (pwr_q & ccr_pkg::POWER_PATH_KEEP_MASK)
				| (ccr_pkg::POWER_PATH_RST & ~ccr_pkg::POWER_PATH_KEEP_MASK);
		end
		else
		begin
			if (wr_stb && ptr_q == ccr_pkg::CHARGE_TIMING_OFS)
				chg_q <= shreg_q;
			if (wr_stb && ptr_q == ccr_pkg::INPUT_THRESHOLD_OFS)
				thr_q <= shreg_q;
			if (wr_stb && ptr_q == ccr_pkg::POWER_PATH_OFS)
				pwr_q[6:0] <= shreg_q[6:0];
			// a new request wins over completion in the same cycle
			if (det_set)
				pwr_q[ccr_pkg::DETECT_BIT] <= 1'b1;
			else if (ext_q.detection_done || (wr_stb && ptr_q == ccr_pkg::POWER_PATH_OFS))
				pwr_q[ccr_pkg::DETECT_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			detection_start_o <= 1'b0;
		else
			detection_start_o <= det_set && !reg_reset_i && !wdog_expire;
	end
	assign detection_active_o = pwr_q[ccr_pkg::DETECT_BIT];

	// ****************************************
	// safety timer
	// ****************************************
	logic [39:0] safe_cnt_q;
	logic        half_q;
	logic [39:0] safe_limit;
	logic        safe_run;
	logic        safe_step;

	assign safe_limit = chg_q[ccr_pkg::FAST_DUR_BIT] ? 40'(SAFETY_SHORT_CYC) << 1
		: 40'(SAFETY_SHORT_CYC);
	assign safe_run   = ext_q.charging && chg_q[ccr_pkg::SAFETY_EN_BIT];
	assign safe_step  = !(pwr_q[ccr_pkg::SLOW_BIT] && ext_q.slow_condition) || half_q;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			safe_cnt_q       <= 40'h0;
			half_q           <= 1'b0;
			safety_expired_o <= 1'b0;
		end
		else if (!safe_run)
		begin
			safe_cnt_q       <= 40'h0;
			half_q           <= 1'b0;
			safety_expired_o <= 1'b0;
		end
		else
		begin
			half_q <= ~half_q;
			if (safe_cnt_q >= safe_limit - 40'h1)
				safety_expired_o <= 1'b1;
			else if (safe_step)
				safe_cnt_q <= safe_cnt_q + 40'h1;
		end
	end

	// ****************************************
	// battery switch
	// ****************************************
	logic [31:0] sw_cnt_q;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sw_cnt_q            <= 32'h0;
			battery_switch_on_o <= 1'b1;
		end
		else if (!pwr_q[ccr_pkg::SW_OFF_BIT])
		begin
			sw_cnt_q            <= 32'h0;
			battery_switch_on_o <= 1'b1;
		end
		else if (!pwr_q[ccr_pkg::SW_DLY_BIT])
			battery_switch_on_o <= 1'b0;
		else if (sw_cnt_q == 32'(SWITCH_DLY_CYC) - 32'h1)
			battery_switch_on_o <= 1'b0;
		else
			sw_cnt_q <= sw_cnt_q + 32'h1;
	end

	// ****************************************
	// configuration fields
	// ****************************************
	assign cfg_o = '{
		term_enable:                 chg_q[ccr_pkg::TERM_EN_BIT],
		watchdog_sel:                chg_q[ccr_pkg::WDOG_LSB +: 2],
		safety_enable:               chg_q[ccr_pkg::SAFETY_EN_BIT],
		fast_charge_duration:        chg_q[ccr_pkg::FAST_DUR_BIT],
		thermal_reg_threshold:       chg_q[ccr_pkg::THERM_BIT],
		cold_zone_current_sel:       chg_q[ccr_pkg::COLD_BIT],
		input_overvoltage_sel:       thr_q[ccr_pkg::OVP_LSB +: 2],
		boost_voltage_sel:           thr_q[ccr_pkg::BOOST_LSB +: 2],
		input_voltage_reg_threshold: thr_q[ccr_pkg::INPUT_VOLTAGE_REG_THRESHOLD_LSB +: 4],
		timer_slowdown_enable:       pwr_q[ccr_pkg::SLOW_BIT],
		warm_zone_voltage_sel:       pwr_q[ccr_pkg::WARM_BIT],
		switch_off_delay_sel:        pwr_q[ccr_pkg::SW_DLY_BIT],
		switch_system_reset_enable:  pwr_q[ccr_pkg::SW_RST_BIT],
		input_threshold_tracking:    pwr_q[ccr_pkg::TRACK_LSB +: 2]
	};
endmodule
`default_nettype wire

// file: sim/ccr_top_chk.sv
// port assertions for the charger configuration register block
`timescale 1ns/1ns
`default_nettype none
module ccr_top_chk (
	// clock and reset
	input wire logic              mclk_i,
	input wire logic              resetn_i,
	// status inputs
	input wire logic              vbus_present_i,
	input wire logic              charging_i,
	input wire logic              detection_done_i,
	input wire logic              reg_reset_i,
	// outputs watched
	input wire ccr_pkg::ccr_cfg_s cfg_o,
	input wire logic              detection_start_o,
	input wire logic              detection_active_o,
	input wire logic              watchdog_fault_o,
	input wire logic              safety_expired_o,
	input wire logic              battery_switch_on_o
);
	// ****************************************
	// properties
	// ****************************************
	localparam logic [20:0] CFG_RST = 21'h17d9ac;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_det_pulse;
		detection_start_o ##1 !detection_start_o;
	endsequence
	a_reset_state: assert property (
		$rose(resetn_i) |-> cfg_o == CFG_RST && battery_switch_on_o)
		else $error("bad state after reset");
	a_reload_regs: assert property (
		reg_reset_i |=> cfg_o == CFG_RST && !watchdog_fault_o)
		else $error("register reset did not reload");
	a_detect_pulse: assert property (
		$rose(detection_active_o) |-> s_det_pulse)
		else $error("detection start not one pulse");
	a_detect_input: assert property (
		$rose(detection_active_o) |-> vbus_present_i && $past(vbus_present_i, 3))
		else $error("detection started without input");
	a_detect_clear: assert property (
		detection_active_o && detection_done_i |-> ##[1:5] !detection_active_o)
		else $error("detection bit not cleared");
	a_expiry_defaults: assert property (
		$rose(watchdog_fault_o) |-> cfg_o[20:14] == 7'h5f && cfg_o.timer_slowdown_enable
			&& !cfg_o.warm_zone_voltage_sel && cfg_o.switch_system_reset_enable)
		else $error("expiry did not restore defaults");
	a_expiry_keeps: assert property (
		$rose(watchdog_fault_o) |-> cfg_o[13:6] == $past(cfg_o[13:6])
			&& cfg_o[3] == $past(cfg_o[3]) && cfg_o[1:0] == $past(cfg_o[1:0]))
		else $error("expiry changed kept fields");
	a_expiry_enabled: assert property (
		$rose(watchdog_fault_o) |-> $past(cfg_o.watchdog_sel) != 2'h0)
		else $error("expiry while supervision off");
	a_safety_off: assert property (
		!cfg_o.safety_enable [*2] |-> !safety_expired_o)
		else $error("safety expiry while disabled");
	a_safety_cause: assert property (
		$rose(safety_expired_o) |-> $past(cfg_o.safety_enable) && $past(charging_i, 3))
		else $error("safety expiry without cause");
	a_switch_delay: assert property (
		$fell(battery_switch_on_o) && cfg_o.switch_off_delay_sel |-> $past(battery_switch_on_o, 8))
		else $error("switch off too early");
endmodule
bind ccr_top ccr_top_chk u_chk (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .vbus_present_i(vbus_present_i),
	.charging_i(charging_i), .detection_done_i(detection_done_i), .reg_reset_i(reg_reset_i),
	.cfg_o(cfg_o), .detection_start_o(detection_start_o),
	.detection_active_o(detection_active_o), .watchdog_fault_o(watchdog_fault_o),
	.safety_expired_o(safety_expired_o), .battery_switch_on_o(battery_switch_on_o)
);
`default_nettype wire

// file: sim/ccr_host.sv
// serial control host model for the charger register block
`timescale 1ns/1ns
`default_nettype none
module ccr_host #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// clock and wire level
	input  wire logic mclk_i,
	input  wire logic sda_line_i,
	// host drive, idle high
	output logic      scl_o,
	output logic      sda_o
);
	logic ack = 1'b0;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ****************************************
	// bit level, 800 ns per bit
	// ****************************************
	task automatic q();
		repeat (2) @(negedge mclk_i);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		q();
		scl_o = 1'b1;
		q();
		q();
		r = sda_line_i;
		scl_o = 1'b0;
		q();
	endtask
	task automatic start();
		sda_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_o = 1'b0;
		q();
		scl_o = 1'b0;
		q();
	endtask
	task automatic stop();
		sda_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_o = 1'b1;
		q();
	endtask
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
	// ****************************************
	// transfers
	// ****************************************
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		tx({ADDR, 1'b0});
		tx(p);
		tx(d);
		stop();
	endtask
	task automatic rd3(input logic [7:0] p, output logic [23:0] d);
		start();
		tx({ADDR, 1'b0});
		tx(p);
		start();
		tx({ADDR, 1'b1});
		rx(1'b0, d[23:16]);
		rx(1'b0, d[15:8]);
		rx(1'b1, d[7:0]);
		stop();
	endtask
	task automatic probe(input logic [6:0] a);
		start();
		tx({a, 1'b0});
		stop();
	endtask
endmodule
`default_nettype wire

// file: sim/ccr_top_tb.sv
// self-checking bench for the charger configuration register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
	begin \
		samples_checked++; \
		if ((a) !== (e)) \
		begin \
			n_mismatch++; \
			$display("Error t=%0t got %h exp %h", $time, (a), (e)); \
		end \
	end
module ccr_top_tb;
	localparam logic [6:0] ADDR = 7'h2a; // arbitrary value
	logic              mclk_i = 1'b0;
	logic              resetn_i = 1'b0;
	logic              vbus = 1'b0;
	logic              charging = 1'b0;
	logic              slow_cond = 1'b0;
	logic              det_done = 1'b0;
	logic              reg_rst = 1'b0;
	logic              scl;
	logic              h_sda;
	logic              sda_oen;
	logic              sda_drv;
	logic              det_start;
	logic              det_act;
	logic              wd_fault;
	logic              safe_exp;
	logic              sw_on;
	ccr_pkg::ccr_cfg_s cfg;
	logic [23:0]       rd;
	logic [7:0]        sf_cfg [4] = '{8'h08, 8'h0c, 8'h08, 8'h00};
	int                sf_lim [4] = '{500, 1000, 1000, 1200};
	int                n_mismatch = 0;
	int                samples_checked = 0;
	int                n_start = 0;
	wire logic         sda_line;
	assign sda_line = h_sda & (sda_oen | sda_drv);
	always #50 mclk_i = ~mclk_i;
	ccr_top #(.DEV_ADDR(ADDR), .WDOG_BASE_CYC(2000), .SAFETY_SHORT_CYC(500),
		.SWITCH_DLY_CYC(50)) dut (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_drv), .sda_oen_o(sda_oen), .vbus_present_i(vbus), .charging_i(charging),
		.slow_condition_i(slow_cond), .detection_done_i(det_done), .reg_reset_i(reg_rst),
		.cfg_o(cfg), .detection_start_o(det_start), .detection_active_o(det_act),
		.watchdog_fault_o(wd_fault), .safety_expired_o(safe_exp), .battery_switch_on_o(sw_on));
	ccr_host #(.ADDR(ADDR)) host (.mclk_i(mclk_i), .sda_line_i(sda_line), .scl_o(scl),
		.sda_o(h_sda));
	always @(posedge mclk_i)
	begin
		if (det_start === 1'b1)
			n_start++;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge mclk_i);
		n_mismatch++;
		complete_run();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		tick(2);
		resetn_i = 1'b1;
		tick(6);
		host.rd3(8'h05, rd);
		`CHK(rd, 24'h9f664c)
		`CHK(sw_on, 1'b1)
		`CHK(cfg.cold_zone_current_sel, 1'b1)
		`CHK(cfg.warm_zone_voltage_sel, 1'b0)
		`CHK(cfg.switch_system_reset_enable, 1'b1)
		`CHK(cfg.input_threshold_tracking, 2'h0)
		host.rd3(8'h07, rd);
		`CHK(rd, 24'h4c0000)
		host.probe(7'h2b);
		`CHK(host.ack, 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			host.wr(8'h06, {i[1:0], ~i[1:0], 4'(i * 5)});
			`CHK(cfg.input_overvoltage_sel, i[1:0])
			`CHK(cfg.boost_voltage_sel, ~i[1:0])
			`CHK(cfg.input_voltage_reg_threshold, 4'(i * 5))
		end
		// supervision periods and expiry
		host.wr(8'h06, 8'h5a);
		host.wr(8'h07, 8'h2b);
		`CHK(cfg.switch_system_reset_enable, 1'b0)
		`CHK(cfg.input_threshold_tracking, 2'h3)
		for (int k = 1; k < 4; k++)
		begin
			host.wr(8'h05, {2'h0, k[1:0], 4'h0});
			tick((2000 << (k - 1)) - 400);
			`CHK(wd_fault, 1'b0)
			tick(800);
			`CHK(wd_fault, 1'b1)
			host.rd3(8'h05, rd);
			`CHK(rd, 24'h9f5a6f)
			`CHK(wd_fault, 1'b0)
		end
		`CHK(sw_on, 1'b0)
		host.wr(8'h05, 8'h00);
		tick(9000);
		`CHK(wd_fault, 1'b0)
		// forced input detection
		host.wr(8'h07, 8'h80);
		`CHK(det_act, 1'b0)
		vbus = 1'b1;
		tick(4);
		host.wr(8'h07, 8'h80);
		`CHK(det_act, 1'b1)
		`CHK(n_start, 1)
		det_done = 1'b1;
		tick(8);
		det_done = 1'b0;
		host.rd3(8'h07, rd);
		`CHK(rd[23:16], 8'h00)
		// battery switch
		host.wr(8'h07, 8'h20);
		`CHK(sw_on, 1'b0)
		host.wr(8'h07, 8'h00);
		`CHK(sw_on, 1'b1)
		host.wr(8'h07, 8'h28);
		`CHK(sw_on, 1'b1)
		tick(50);
		`CHK(sw_on, 1'b0)
		// safety timer durations and slow-down
		host.wr(8'h07, 8'h40);
		for (int j = 0; j < 4; j++)
		begin
			host.wr(8'h05, sf_cfg[j]);
			slow_cond = (j == 2);
			charging = 1'b1;
			tick(sf_lim[j] - 20);
			`CHK(safe_exp, 1'b0)
			tick(40);
			`CHK(safe_exp, j < 3)
			charging = 1'b0;
			host.wr(8'h05, 8'h00);
		end
		reg_rst = 1'b1;
		tick(1);
		reg_rst = 1'b0;
		host.rd3(8'h05, rd);
		`CHK(rd, 24'h9f664c)
		complete_run();
	end
endmodule
`default_nettype wire
